/* hw/pin_io_override.v */
// Sixteen-pin I/O unit with bulk update, hardware overrides and over-current inputs
`timescale 1ns/10ps
`include "pin_io_map.vh"

module pin_io_override (
    // Clock and reset
    input  wire        SYS_CLK,
    input  wire        RST,
    // APB slave
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output wire        PREADY,
    output wire        PSLVERR,
    output wire [31:0] PRDATA,
    // Pins
    input  wire [15:0] PIN_IN,
    output wire [15:0] PIN_OUT,
    output wire [15:0] PIN_OE_N,
    // Standalone alternate functions for pins 9..15
    input  wire        ALT_FUNC_EN,
    input  wire [6:0]  ALT_OUT,
    input  wire [6:0]  ALT_OE_N,
    // Over-current comparators and their thresholds
    input  wire        OC_IN_A,
    input  wire        OC_IN_B,
    output wire [7:0]  OC_THRESH_A,
    output wire [7:0]  OC_THRESH_B,
    // Open-drain interrupt
    output wire        IRQ_OUT_LOW,
    output wire        IRQ_OE_N
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg  [2:0]  cfg_q        [0:15];
    reg  [2:0]  staged_cfg_q [0:15];
    reg  [4:0]  src_sel_q    [0:3];
    reg  [15:0] out_mask_q   [0:3];
    reg  [7:0]  oc_cnt_q     [0:1];
    reg  [15:0] combined_q;
    reg  [15:0] staged_comb_q;
    reg  [15:0] ovr_value_q;
    reg  [15:0] pin_s1_q;
    reg  [15:0] pin_s2_q;
    reg  [15:0] pin_prev_q;
    reg  [15:0] pin_flags_q;
    reg  [15:0] pin_out_q;
    reg  [15:0] pin_oe_n_q;
    reg  [3:0]  match_q;
    reg  [3:0]  arm_q;
    reg  [3:0]  pending_q;
    reg  [3:0]  ovr_flags_q;
    reg  [3:0]  ovr_en_q;
    reg  [2:0]  top_en_q;
    reg         bulk_req_q;
    reg         oc_ctrl_q;
    reg         oc_active_q;
    reg  [1:0]  oc_in_en_q;
    reg  [1:0]  oc_s1_q;
    reg  [1:0]  oc_s2_q;
    reg  [1:0]  oc_level_q;
    reg  [1:0]  oc_lvl_prev_q;
    reg  [1:0]  oc_change_q;
    reg  [7:0]  thresh_a_q;
    reg  [7:0]  thresh_b_q;
    reg  [7:0]  filter_time_q;
    reg  [6:0]  tick_cnt_q;
    reg         irq_q;
    reg  [31:0] rdata_q;
    reg  [31:0] rd_d;
    reg         rd_hit;
    reg  [15:0] forced;
    reg  [3:0]  src_val;
    reg  [15:0] cfg_out_view;
    reg  [15:0] evt_view;
    integer     i;
    integer     j;
    integer     k;

    wire [7:0]  idx      = PADDR[9:2];
    wire        setup    = PSEL & ~PENABLE;
    wire        wr       = PSEL & PENABLE & PWRITE;
    wire        tick     = (tick_cnt_q == (`TICK_CYC - 1));
    wire [3:0]  hit      = arm_q & ~(src_val ^ match_q);
    wire [3:0]  fire     = hit & ~pending_q;
    wire        bulk_ok  = bulk_req_q & ~(|pending_q);
    wire [15:0] pin_edge = pin_s2_q ^ pin_prev_q;
    wire [2:0]  top_status;

    assign top_status[`TOP_PIN_BIT] = |pin_flags_q;
    assign top_status[`TOP_OVR_BIT] = |(ovr_flags_q & ovr_en_q);
    assign top_status[`TOP_OC_BIT]  = |oc_change_q;

    // ----------------------------------------------------------------
    // Override sources and forced pins
    // ----------------------------------------------------------------
    always @* begin
        forced = `RST_PINS;
        for (k = 0; k < 4; k = k + 1) begin
            if (src_sel_q[k] == `SRC_OC_A)
                src_val[k] = oc_level_q[0];
            else if (src_sel_q[k] == `SRC_OC_B)
                src_val[k] = oc_level_q[1];
            else
                src_val[k] = pin_s2_q[src_sel_q[k][3:0]];
            if (pending_q[k])
                forced = forced | out_mask_q[k];
        end
        for (k = 0; k < 16; k = k + 1) begin
            cfg_out_view[k] = staged_cfg_q[k][`CFG_OUT_BIT];
            evt_view[k]     = cfg_q[k][`CFG_EVT_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Synchronisers; a filtered change must outlast filter_time ticks
    // ----------------------------------------------------------------
    always @(posedge SYS_CLK) begin
        if (RST) begin
            pin_s1_q      <= `RST_PINS;
            pin_s2_q      <= `RST_PINS;
            pin_prev_q    <= `RST_PINS;
            oc_s1_q       <= 2'b00;
            oc_s2_q       <= 2'b00;
            tick_cnt_q    <= 7'h00;
            oc_level_q    <= 2'b00;
            oc_lvl_prev_q <= 2'b00;
            oc_active_q   <= 1'b0;
            oc_cnt_q[0]   <= `RST_BYTE;
            oc_cnt_q[1]   <= `RST_BYTE;
        end else begin
            pin_s1_q      <= PIN_IN;
            pin_s2_q      <= pin_s1_q;
            pin_prev_q    <= pin_s2_q;
            oc_s1_q       <= {OC_IN_B, OC_IN_A};
            oc_s2_q       <= oc_s1_q;
            oc_lvl_prev_q <= oc_level_q;
            tick_cnt_q    <= tick ? 7'h00 : tick_cnt_q + 7'h01;
            oc_active_q   <= oc_ctrl_q;
            for (j = 0; j < 2; j = j + 1) begin
                if (!oc_ctrl_q || !oc_in_en_q[j] || oc_s2_q[j] == oc_level_q[j]) begin
                    oc_cnt_q[j] <= `RST_BYTE;
                end else if (tick) begin
                    if (oc_cnt_q[j] >= filter_time_q) begin
                        oc_level_q[j] <= oc_s2_q[j];
                        oc_cnt_q[j]   <= `RST_BYTE;
                    end else begin
                        oc_cnt_q[j] <= oc_cnt_q[j] + 8'h01;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers, overrides and bulk update
    // ----------------------------------------------------------------
    always @(posedge SYS_CLK) begin
        if (RST) begin
            combined_q    <= `RST_PINS;
            staged_comb_q <= `RST_PINS;
            ovr_value_q   <= `RST_PINS;
            pin_flags_q   <= `RST_PINS;
            match_q       <= `RST_NIBBLE;
            arm_q         <= `RST_NIBBLE;
            pending_q     <= `RST_NIBBLE;
            ovr_flags_q   <= `RST_NIBBLE;
            ovr_en_q      <= `RST_NIBBLE;
            top_en_q      <= 3'h0;
            bulk_req_q    <= 1'b0;
            oc_ctrl_q     <= 1'b0;
            oc_in_en_q    <= 2'b00;
            oc_change_q   <= 2'b00;
            thresh_a_q    <= `RST_BYTE;
            thresh_b_q    <= `RST_BYTE;
            filter_time_q <= `RST_BYTE;
            for (i = 0; i < 16; i = i + 1) begin
                cfg_q[i]        <= `RST_CFG;
                staged_cfg_q[i] <= `RST_CFG;
            end
            for (i = 0; i < 4; i = i + 1) begin
                src_sel_q[i]  <= `RST_SRC;
                out_mask_q[i] <= `RST_PINS;
            end
        end else begin
            // Overrides latch until software disarms them
            pending_q <= (pending_q | hit) & arm_q;
            // Event flags: a new event wins over a same-cycle clear
            pin_flags_q <= (pin_flags_q & ~((wr && idx == `IDX_PIN_IRQ_FLAGS) ? PWDATA[15:0] : `RST_PINS))
                           | (pin_edge & evt_view);
            ovr_flags_q <= (ovr_flags_q & ~((wr && idx == `IDX_OVR_IRQ_FLAGS) ? PWDATA[3:0] : `RST_NIBBLE))
                           | fire;
            oc_change_q <= (oc_change_q & ~((wr && idx == `IDX_OC_CHANGE) ? PWDATA[1:0] : 2'b00))
                           | (oc_level_q ^ oc_lvl_prev_q);

            if (bulk_ok) begin
                for (i = 0; i < 16; i = i + 1)
                    cfg_q[i] <= staged_cfg_q[i];
                combined_q <= cfg_out_view;
            end else if (wr && idx == `IDX_COMBINED_OUT) begin
                combined_q <= (PWDATA[15:0] & ~forced) | (combined_q & forced);
            end else if (wr && idx[7:4] == `IDX_PIN_CONFIG_HI) begin
                cfg_q[idx[3:0]] <= PWDATA[2:0];
                if (!forced[idx[3:0]])
                    combined_q[idx[3:0]] <= PWDATA[`CFG_OUT_BIT];
            end

            // Request set by software wins over acceptance in the same cycle
            if (wr && idx == `IDX_BULK_UPDATE && PWDATA[0])
                bulk_req_q <= 1'b1;
            else if (bulk_ok)
                bulk_req_q <= 1'b0;

            if (wr) begin
                if (idx[7:4] == `IDX_STAGED_CFG_HI)
                    staged_cfg_q[idx[3:0]] <= PWDATA[2:0];
                if (idx[7:2] == `IDX_SRC_SEL_HI)
                    src_sel_q[idx[1:0]] <= PWDATA[4:0];
                if (idx[7:3] == `IDX_OUT_MASK_HI && !idx[0])
                    out_mask_q[idx[2:1]] <= PWDATA[15:0];
                case (idx)
                    `IDX_TOP_IRQ_ENABLE:   top_en_q      <= PWDATA[2:0];
                    `IDX_MATCH_LEVEL:      match_q       <= PWDATA[3:0];
                    `IDX_OVERRIDE_ARM:     arm_q         <= PWDATA[3:0];
                    `IDX_OVR_IRQ_ENABLE:   ovr_en_q      <= PWDATA[3:0];
                    `IDX_STAGED_COMB_OUT:  staged_comb_q <= PWDATA[15:0];
                    `IDX_OVERRIDE_VALUE:   ovr_value_q   <= PWDATA[15:0];
                    `IDX_OC_CTRL:          oc_ctrl_q     <= PWDATA[`OC_CTRL_BIT];
                    `IDX_OC_INPUT_EN:      oc_in_en_q    <= PWDATA[1:0];
                    `IDX_OC_THRESH_A:      thresh_a_q    <= PWDATA[7:0];
                    `IDX_OC_THRESH_B:      thresh_b_q    <= PWDATA[7:0];
                    `IDX_OC_FILTER_TIME:   filter_time_q <= PWDATA[7:0];
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1) begin : pin_drv
            always @(posedge SYS_CLK) begin
                if (RST) begin
                    pin_out_q[g]  <= 1'b0;
                    pin_oe_n_q[g] <= 1'b1;
                end else if (ALT_FUNC_EN && g >= `FIRST_ALT_PIN) begin
                    pin_out_q[g]  <= ALT_OUT[(g >= `FIRST_ALT_PIN) ? g - `FIRST_ALT_PIN : 0];
                    pin_oe_n_q[g] <= ALT_OE_N[(g >= `FIRST_ALT_PIN) ? g - `FIRST_ALT_PIN : 0];
                end else if (forced[g]) begin
                    pin_out_q[g]  <= ovr_value_q[g];
                    pin_oe_n_q[g] <= 1'b0;
                end else begin
                    pin_out_q[g]  <= combined_q[g];
                    pin_oe_n_q[g] <= ~cfg_q[g][`CFG_DIR_BIT];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Interrupt pin: open drain, pulled low while asserted
    // ----------------------------------------------------------------
    always @(posedge SYS_CLK) begin
        if (RST)
            irq_q <= 1'b0;
        else
            irq_q <= |(top_status & top_en_q);
    end

    // ----------------------------------------------------------------
    // APB read path, captured in the setup cycle
    // ----------------------------------------------------------------
    always @* begin
        rd_d   = 32'h0000_0000;
        rd_hit = 1'b1;
        if (idx[7:4] == `IDX_PIN_CONFIG_HI) begin
            rd_d[2:0]          = cfg_q[idx[3:0]];
            rd_d[`CFG_OUT_BIT] = combined_q[idx[3:0]];
        end else if (idx[7:4] == `IDX_STAGED_CFG_HI) begin
            rd_d[2:0] = staged_cfg_q[idx[3:0]];
        end else if (idx[7:2] == `IDX_SRC_SEL_HI) begin
            rd_d[4:0] = src_sel_q[idx[1:0]];
        end else if (idx[7:3] == `IDX_OUT_MASK_HI && !idx[0]) begin
            rd_d[15:0] = out_mask_q[idx[2:1]];
        end else begin
            case (idx)
                `IDX_TOP_IRQ_STATUS:   rd_d[2:0]  = top_status;
                `IDX_TOP_IRQ_ENABLE:   rd_d[2:0]  = top_en_q;
                `IDX_PIN_LEVEL_STATUS: rd_d[15:0] = pin_s2_q;
                `IDX_PIN_IRQ_FLAGS:    rd_d[15:0] = pin_flags_q;
                `IDX_MATCH_LEVEL:      rd_d[3:0]  = match_q;
                `IDX_OVERRIDE_ARM:     rd_d[3:0]  = arm_q;
                `IDX_OVERRIDE_PENDING: rd_d[3:0]  = pending_q;
                `IDX_OVR_IRQ_FLAGS:    rd_d[3:0]  = ovr_flags_q;
                `IDX_OVR_IRQ_ENABLE:   rd_d[3:0]  = ovr_en_q;
                `IDX_COMBINED_OUT:     rd_d[15:0] = combined_q;
                `IDX_STAGED_COMB_OUT:  rd_d[15:0] = staged_comb_q;
                `IDX_BULK_UPDATE:      rd_d[0]    = bulk_req_q;
                `IDX_OVERRIDE_VALUE:   rd_d[15:0] = ovr_value_q;
                `IDX_OC_CTRL:          rd_d[1:0]  = {oc_active_q, oc_ctrl_q};
                `IDX_OC_LEVEL:         rd_d[1:0]  = oc_level_q;
                `IDX_OC_CHANGE:        rd_d[1:0]  = oc_change_q;
                `IDX_OC_INPUT_EN:      rd_d[1:0]  = oc_in_en_q;
                `IDX_OC_THRESH_A:      rd_d[7:0]  = thresh_a_q;
                `IDX_OC_THRESH_B:      rd_d[7:0]  = thresh_b_q;
                `IDX_OC_FILTER_TIME:   rd_d[7:0]  = filter_time_q;
                default:               rd_hit     = 1'b0;
            endcase
        end
    end

    reg hit_q;
    always @(posedge SYS_CLK) begin
        if (RST) begin
            rdata_q <= 32'h0000_0000;
            hit_q   <= 1'b0;
        end else if (setup) begin
            rdata_q <= PWRITE ? 32'h0000_0000 : rd_d;
            hit_q   <= rd_hit;
        end
    end

    assign PREADY      = 1'b1;
    assign PSLVERR     = PSEL & PENABLE & ~hit_q;
    assign PRDATA      = rdata_q;
    assign PIN_OUT     = pin_out_q;
    assign PIN_OE_N    = pin_oe_n_q;
    assign OC_THRESH_A = thresh_a_q;
    assign OC_THRESH_B = thresh_b_q;
    assign IRQ_OUT_LOW = 1'b0;
    assign IRQ_OE_N    = ~irq_q;

endmodule

/* hw/pin_io_map.vh */
// Register indices, field positions, reset values and timing for the pin I/O block
`ifndef PIN_IO_MAP_VH
`define PIN_IO_MAP_VH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define IDX_TOP_IRQ_STATUS   8'h10
`define IDX_TOP_IRQ_ENABLE   8'h14
`define IDX_PIN_LEVEL_STATUS 8'h20
`define IDX_PIN_IRQ_FLAGS    8'h22
`define IDX_PIN_CONFIG_HI    4'h3
`define IDX_STAGED_CFG_HI    4'h4
`define IDX_SRC_SEL_HI       6'h14
`define IDX_MATCH_LEVEL      8'h54
`define IDX_OVERRIDE_ARM     8'h55
`define IDX_OVERRIDE_PENDING 8'h56
`define IDX_OVR_IRQ_FLAGS    8'h57
`define IDX_OVR_IRQ_ENABLE   8'h58
`define IDX_COMBINED_OUT     8'h59
`define IDX_STAGED_COMB_OUT  8'h5B
`define IDX_BULK_UPDATE      8'h5D
`define IDX_OUT_MASK_HI      5'h0C
`define IDX_OVERRIDE_VALUE   8'h68
`define IDX_OC_CTRL          8'h80
`define IDX_OC_LEVEL         8'h81
`define IDX_OC_CHANGE        8'h82
`define IDX_OC_INPUT_EN      8'h83
`define IDX_OC_THRESH_A      8'h84
`define IDX_OC_THRESH_B      8'h86
`define IDX_OC_FILTER_TIME   8'h88

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define CFG_DIR_BIT     0
`define CFG_OUT_BIT     1
`define CFG_EVT_BIT     2
`define TOP_PIN_BIT     0
`define TOP_OVR_BIT     1
`define TOP_OC_BIT      2
`define OC_CTRL_BIT     0
`define OC_ACTIVE_BIT   1
`define SRC_OC_A        5'h10
`define SRC_OC_B        5'h11
`define FIRST_ALT_PIN   9

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_CFG         3'h0
`define RST_PINS        16'h0000
`define RST_NIBBLE      4'h0
`define RST_BYTE        8'h00
`define RST_SRC         5'h00

// ----------------------------------------------------------------
// Timing: filter tick of 1 us at 8 ns clock
// ----------------------------------------------------------------
`define TICK_NS         1000
`define CLK_NS          8
`define TICK_CYC        (`TICK_NS / `CLK_NS)

`endif

/* verification/pin_io_override_props.sv */
// Port-level concurrent checks for the pin I/O override block
`timescale 1ns/10ps
`include "pin_io_map.vh"
module pin_io_override_props (
    // Clock, reset and bus
    input wire        SYS_CLK,
    input wire        RST,
    input wire        PSEL,
    input wire        PENABLE,
    input wire        PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    input wire        PSLVERR,
    input wire [31:0] PRDATA,
    // Pins and interrupt
    input wire [15:0] PIN_IN,
    input wire [15:0] PIN_OUT,
    input wire [15:0] PIN_OE_N,
    input wire        ALT_FUNC_EN,
    input wire [6:0]  ALT_OUT,
    input wire [6:0]  ALT_OE_N,
    input wire        IRQ_OUT_LOW,
    input wire        IRQ_OE_N
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    wire       rd_acc = PSEL && PENABLE && !PWRITE;
    wire       wr_acc = PSEL && PENABLE && PWRITE;
    wire [7:0] idx    = PADDR[9:2];
    reg  [2:0] en_q;
    // Shadow of the top enable: the line may only fall for an enabled source
    always @(posedge SYS_CLK) begin
        if (RST)
            en_q <= 3'h0;
        else if (wr_acc && idx == `IDX_TOP_IRQ_ENABLE)
            en_q <= PWDATA[2:0];
    end
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    sequence s_pins_steady;
        $stable(PIN_IN)[*3];
    endsequence
    sequence s_level_read;
        rd_acc && idx == `IDX_PIN_LEVEL_STATUS && !$past(RST, 3);
    endsequence
    property p_level_read;
        s_pins_steady ##0 s_level_read |-> PRDATA[15:0] == PIN_IN;
    endproperty
    property p_level_upper;
        s_level_read |-> PRDATA[31:16] == 16'h0000;
    endproperty
    property p_cfg_read;
        rd_acc && idx[7:4] == `IDX_PIN_CONFIG_HI |-> !PSLVERR && PRDATA[31:3] == 29'h0;
    endproperty
    property p_irq_data;
        IRQ_OUT_LOW == 1'b0;
    endproperty
    property p_irq_enable;
        !IRQ_OE_N |-> $past(en_q) != 3'h0;
    endproperty
    property p_irq_release;
        $rose(IRQ_OE_N) |-> $past(wr_acc, 2);
    endproperty
    property p_alt_out;
        ALT_FUNC_EN && $past(ALT_FUNC_EN) && !$past(RST) |-> PIN_OUT[15:9] == $past(ALT_OUT);
    endproperty
    property p_alt_oe;
        ALT_FUNC_EN && $past(ALT_FUNC_EN) && !$past(RST) |-> PIN_OE_N[15:9] == $past(ALT_OE_N);
    endproperty
    a_level_read: assert property (p_level_read) else $error("level read differs from pins");
    a_level_upper: assert property (p_level_upper) else $error("level read upper bits set");
    a_cfg_read: assert property (p_cfg_read) else $error("pin config read malformed");
    a_irq_data: assert property (p_irq_data) else $error("interrupt data not low");
    a_irq_enable: assert property (p_irq_enable) else $error("interrupt with no source enabled");
    a_irq_release: assert property (p_irq_release) else $error("interrupt released without write");
    a_alt_out: assert property (p_alt_out) else $error("alternate output not passed");
    a_alt_oe: assert property (p_alt_oe) else $error("alternate enable not passed");
endmodule

bind pin_io_override pin_io_override_props i_props (.SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSLVERR(PSLVERR), .PRDATA(PRDATA),
    .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N), .ALT_FUNC_EN(ALT_FUNC_EN), .ALT_OUT(ALT_OUT),
    .ALT_OE_N(ALT_OE_N), .IRQ_OUT_LOW(IRQ_OUT_LOW), .IRQ_OE_N(IRQ_OE_N));

/* verification/pin_partner.sv */
// Behavioural model of the switches and sensors wired to the pins
`timescale 1ns/10ps
module pin_partner (
    // Pin side of the block
    input  wire [15:0] pin_out,
    input  wire [15:0] pin_oe_n,
    // Levels the sensors present on released pins
    input  wire [15:0] ext_drive,
    output wire [15:0] pin_level
);
    // Pins 1 and 10 only drive loads; the board holds them low, reset included
    localparam [15:0] OUT_ONLY = 16'h0402;
    assign pin_level = (~pin_oe_n & pin_out) | (pin_oe_n & ~OUT_ONLY & ext_drive);
endmodule

/* verification/pin_io_override_tb.sv */
// Self-checking testbench for the pin I/O override block
`timescale 1ns/10ps
`include "pin_io_map.vh"
module pin_io_override_tb;
    reg         sys_clk, rst, psel, penable, pwrite, alt_en, oc_a;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rdata;
    reg  [15:0] ext_drive;
    reg  [6:0]  alt_out, alt_oe_n;
    reg         rerr;
    wire        pready, pslverr, irq_low, irq_oe_n;
    wire [31:0] prdata;
    wire [15:0] pin_in, pin_out, pin_oe_n;
    wire [7:0]  thr_a;
    integer     mismatches, compares;

    pin_io_override i_dut (.SYS_CLK(sys_clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PSLVERR(pslverr), .PRDATA(prdata), .PIN_IN(pin_in),
        .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n), .ALT_FUNC_EN(alt_en), .ALT_OUT(alt_out), .ALT_OE_N(alt_oe_n),
        .OC_IN_A(oc_a), .OC_IN_B(1'b0), .OC_THRESH_A(thr_a), .OC_THRESH_B(), .IRQ_OUT_LOW(irq_low),
        .IRQ_OE_N(irq_oe_n));
    pin_partner i_partner (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_drive(ext_drive), .pin_level(pin_in));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task give_verdict;
        begin
            $display("compares %0d mismatches %0d", compares, mismatches);
            if (mismatches == 0 && compares > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    // Full setup and access phases; request held until pready is seen high
    task apb(input wr, input [7:0] idx, input [31:0] wd);
        integer n;
        begin
            @(posedge sys_clk);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= {2'h0, idx, 2'h0};
            pwdata <= wd;
            @(posedge sys_clk);
            penable <= 1'b1;
            n = 0;
            @(posedge sys_clk);
            while (pready !== 1'b1 && n < 16) begin
                n = n + 1;
                @(posedge sys_clk);
            end
            if (pready !== 1'b1) begin
                mismatches = mismatches + 1;
                give_verdict;
            end
            rdata = prdata;
            rerr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rchk(input [7:0] idx, input [31:0] exp);
        begin
            apb(1'b0, idx, 32'h0);
            chk(rdata, exp);
        end
    endtask
    // Sampled on the falling edge, clear of the register updates
    task wait_irq(input lvl);
        integer n;
        begin
            n = 0;
            @(negedge sys_clk);
            while (irq_oe_n !== lvl && n < 600) begin
                n = n + 1;
                @(negedge sys_clk);
            end
            chk(32'(irq_oe_n), 32'(lvl));
            if (irq_oe_n !== lvl)
                give_verdict;
        end
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_regs;
        begin
            rchk(8'h33, 32'h0);
            apb(1'b0, 8'h5E, 32'h0);
            chk({31'h0, rerr}, 32'h1);
            apb(1'b1, 8'h33, 32'h3);
            rchk(`IDX_COMBINED_OUT, 32'h8);
            apb(1'b1, `IDX_COMBINED_OUT, 32'hF0);
            rchk(8'h33, 32'h1);
            rchk(8'h34, 32'h2);
            @(negedge sys_clk);
            chk(32'(pin_oe_n[3]), 32'h0);
            $display("register test done");
        end
    endtask
    task t_level;
        begin
            @(posedge sys_clk);
            ext_drive <= 16'h81C0;
            apb(1'b1, 8'h30, 32'h4);
            rchk(`IDX_PIN_LEVEL_STATUS, 32'h81C0);
            ext_drive <= 16'h81C1;
            repeat (4) @(posedge sys_clk);
            rchk(`IDX_TOP_IRQ_STATUS, 32'h1);
            apb(1'b1, `IDX_PIN_IRQ_FLAGS, 32'h0);
            rchk(`IDX_PIN_IRQ_FLAGS, 32'h1);
            apb(1'b1, `IDX_PIN_IRQ_FLAGS, 32'h1);
            rchk(`IDX_PIN_IRQ_FLAGS, 32'h0);
            $display("level test done");
        end
    endtask
    task t_bulk;
        begin
            apb(1'b1, 8'h45, 32'h3);
            apb(1'b1, `IDX_STAGED_COMB_OUT, 32'h0);
            apb(1'b1, `IDX_BULK_UPDATE, 32'h1);
            rchk(`IDX_BULK_UPDATE, 32'h0);
            rchk(8'h35, 32'h3);
            rchk(`IDX_COMBINED_OUT, 32'h20);
            $display("bulk test done");
        end
    endtask
    task t_override;
        begin
            apb(1'b1, 8'h50, 32'h0);
            apb(1'b1, `IDX_MATCH_LEVEL, 32'h0);
            apb(1'b1, 8'h60, 32'h100);
            apb(1'b1, `IDX_OVERRIDE_VALUE, 32'h100);
            apb(1'b1, `IDX_OVR_IRQ_ENABLE, 32'h1);
            apb(1'b1, `IDX_TOP_IRQ_ENABLE, 32'h2);
            apb(1'b1, `IDX_OVERRIDE_ARM, 32'h1);
            ext_drive <= 16'h81C0;
            wait_irq(1'b0);
            chk({pin_out[8], pin_oe_n[8]}, 32'h2);
            rchk(`IDX_OVERRIDE_PENDING, 32'h1);
            apb(1'b1, `IDX_COMBINED_OUT, 32'h120);
            rchk(`IDX_COMBINED_OUT, 32'h20);
            repeat (2) @(negedge sys_clk);
            chk(32'(pin_out[8]), 32'h1);
            apb(1'b1, `IDX_BULK_UPDATE, 32'h1);
            rchk(`IDX_BULK_UPDATE, 32'h1);
            apb(1'b1, `IDX_OVERRIDE_ARM, 32'h0);
            repeat (3) @(posedge sys_clk);
            rchk(`IDX_BULK_UPDATE, 32'h0);
            chk({pin_out[8], pin_oe_n[8]}, 32'h1);
            apb(1'b1, `IDX_OVR_IRQ_FLAGS, 32'h1);
            wait_irq(1'b1);
            $display("override test done");
        end
    endtask
    task t_overcurrent;
        begin
            apb(1'b1, `IDX_OC_CTRL, 32'h0);
            rchk(`IDX_OC_CTRL, 32'h0);
            apb(1'b1, `IDX_OC_THRESH_A, 32'h3C);
            apb(1'b1, `IDX_OC_FILTER_TIME, 32'h0);
            apb(1'b1, `IDX_OC_INPUT_EN, 32'h1);
            apb(1'b1, `IDX_TOP_IRQ_ENABLE, 32'h4);
            apb(1'b1, `IDX_OC_CTRL, 32'h1);
            chk(32'(thr_a), 32'h3C);
            oc_a <= 1'b1;
            wait_irq(1'b0);
            rchk(`IDX_OC_LEVEL, 32'h1);
            apb(1'b1, 8'h51, `SRC_OC_A);
            apb(1'b1, `IDX_MATCH_LEVEL, 32'h2);
            apb(1'b1, `IDX_OVERRIDE_ARM, 32'h2);
            rchk(`IDX_OVERRIDE_PENDING, 32'h2);
            apb(1'b1, `IDX_OVERRIDE_ARM, 32'h0);
            apb(1'b1, `IDX_OC_CHANGE, 32'h1);
            wait_irq(1'b1);
            apb(1'b1, `IDX_OC_CTRL, 32'h0);
            oc_a <= 1'b0;
            repeat (400) @(posedge sys_clk);
            rchk(`IDX_OC_CHANGE, 32'h0);
            $display("overcurrent test done");
        end
    endtask
    task t_alt;
        begin
            alt_en <= 1'b1;
            alt_out <= 7'h55;
            alt_oe_n <= 7'h2A;
            repeat (3) @(negedge sys_clk);
            chk({pin_out[15:9], pin_oe_n[15:9]}, 32'h2AAA);
            $display("alternate test done");
        end
    endtask
    initial begin
        {rst, psel, penable, pwrite, alt_en, oc_a} = 6'h20;
        {paddr, pwdata, ext_drive, alt_out, alt_oe_n} = 74'h0;
        mismatches = 0;
        compares = 0;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs;
        t_level;
        t_bulk;
        t_override;
        t_overcurrent;
        t_alt;
        give_verdict;
    end
endmodule
